// ---- hdl/gauge_port_pkg.sv ----
// Shared constants, timing counts and types for the gauge host port and power modes
package gauge_port_pkg;

  // ------------------------------------------------------------
  // Serial target addressing
  // ------------------------------------------------------------
  localparam logic [6:0] TARGET_ADDR = 7'h55;
  localparam logic [7:0] ADDR_BYTE_WR = 8'haa;
  localparam logic [7:0] ADDR_BYTE_RD = 8'hab;
  localparam logic [7:0] READ_FILL = 8'hff;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // ------------------------------------------------------------
  // Clock rates
  // ------------------------------------------------------------
  localparam longint unsigned SYS_CLK_PERIOD_PS = 64'd4000;
  localparam longint unsigned LINK_CLK_PERIOD_PS = 64'd6000;
  localparam longint unsigned PS_PER_US = 64'd1000000;

  // ------------------------------------------------------------
  // Times in their own units and derived cycle counts
  // ------------------------------------------------------------
  localparam longint unsigned BUS_TIMEOUT_S = 64'd2;
  localparam longint unsigned BUS_TIMEOUT_PS = BUS_TIMEOUT_S * 64'd1000000000000;
  // Least time: round up
  localparam int unsigned BUS_TIMEOUT_CYC =
    32'((BUS_TIMEOUT_PS + LINK_CLK_PERIOD_PS - 64'd1) / LINK_CLK_PERIOD_PS);

  localparam longint unsigned STRETCH_SLEEP_US = 64'd100;
  // Longest time: round down
  localparam int unsigned STRETCH_SLEEP_CYC =
    32'((STRETCH_SLEEP_US * PS_PER_US) / LINK_CLK_PERIOD_PS);

  localparam longint unsigned STRETCH_ACTIVE_MS = 64'd4;
  localparam int unsigned STRETCH_ACTIVE_CYC =
    32'((STRETCH_ACTIVE_MS * 64'd1000 * PS_PER_US) / LINK_CLK_PERIOD_PS);

  localparam longint unsigned WAKE_LOW_TIME_US = 64'd10;
  localparam logic [11:0] WAKE_LOW_TIME_CYC =
    12'((WAKE_LOW_TIME_US * PS_PER_US + SYS_CLK_PERIOD_PS - 64'd1) / SYS_CLK_PERIOD_PS);

  localparam longint unsigned SHUTDOWN_ENTRY_MS = 64'd250;

  // Cycles a released bus must stay low before it counts as held from outside
  localparam logic [3:0] STUCK_SETTLE_CYC = 4'hf;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    M_INIT,
    M_NORMAL,
    M_SLEEP,
    M_SHUTDOWN
  } power_mode_t;

  typedef enum logic [3:0] {
    L_IDLE,
    L_ADDR,
    L_ACK,
    L_WR,
    L_RD,
    L_RDACK,
    L_WAIT,
    L_SKIP,
    L_STUCK
  } link_state_t;

  typedef struct packed {
    logic is_addr;
    logic is_read;
    logic [7:0] data;
  } link_req_t;

endpackage : gauge_port_pkg

// ---- hdl/gauge_host_port.sv ----
// Serial target port and power-mode controller of the gauge
`timescale 1ns/10ps
`default_nettype none
module gauge_host_port #(
  parameter int unsigned BUS_TIMEOUT_CYC = gauge_port_pkg::BUS_TIMEOUT_CYC,
  parameter int unsigned STRETCH_SLEEP_CYC = gauge_port_pkg::STRETCH_SLEEP_CYC,
  parameter int unsigned STRETCH_ACTIVE_CYC = gauge_port_pkg::STRETCH_ACTIVE_CYC
) (
  // System clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Link clock
  input wire logic clk_link,
  // Serial pins
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // Interrupt pin
  input wire logic alert_in,
  output logic alert_out,
  output logic alert_oe_n,
  // Power sequencing
  input wire logic por_done,
  output logic por_start,
  output logic regulator_enable,
  output gauge_port_pkg::power_mode_t power_mode,
  // Sleep control
  input wire logic sleep_enable,
  input wire logic signed [15:0] measured_current,
  input wire logic [15:0] sleep_current_level,
  // Commands decoded from serial traffic
  input wire logic shutdown_cmd,
  input wire logic config_update,
  output logic gauging_enable,
  // Charge accumulation alert
  input wire logic charge_alert_enable,
  input wire logic [31:0] summed_charge,
  input wire logic [31:0] summed_charge_duration,
  input wire logic [31:0] charge_alert_level,
  input wire logic [31:0] duration_alert_level,
  output logic charge_flag,
  // State-of-charge level trigger
  input wire logic charging,
  input wire logic [7:0] soc,
  input wire logic [7:0] charge_level_trigger_chg,
  input wire logic [7:0] charge_level_trigger_dsg,
  output logic level_flag,
  input wire logic flag_clear,
  // Byte handshake toward command logic
  output logic cmd_valid,
  output gauge_port_pkg::link_req_t cmd,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_data
);

  // ------------------------------------------------------------
  // Link domain: reset and input synchronisers
  // ------------------------------------------------------------
  logic [1:0] link_rst_sync;
  logic link_rst;
  logic [4:0] lk_s1;
  logic [4:0] lk_s2;
  logic scl_d;
  logic sda_d;
  logic mode_sleep;
  logic mode_off;
  logic ack_tog;

  always_ff @(posedge clk_link) begin
    link_rst_sync <= {link_rst_sync[0], rst};
  end
  assign link_rst = link_rst_sync[1];

  always_ff @(posedge clk_link) begin
    lk_s1 <= {scl_in, sda_in, mode_sleep, mode_off, ack_tog};
    lk_s2 <= lk_s1;
    scl_d <= lk_s2[4];
    sda_d <= lk_s2[3];
  end

  wire scl_q = lk_s2[4];
  wire sda_q = lk_s2[3];
  wire link_sleep = lk_s2[2];
  wire link_off = lk_s2[1];
  wire ack_q = lk_s2[0];
  wire scl_rise = scl_q & ~scl_d;
  wire scl_fall = ~scl_q & scl_d;
  wire start_seen = scl_q & scl_d & sda_d & ~sda_q;
  wire stop_seen = scl_q & scl_d & ~sda_d & sda_q;

  // ------------------------------------------------------------
  // Link domain: bus watchdog
  // ------------------------------------------------------------
  logic [31:0] bus_cnt;
  logic [3:0] settle_cnt;
  gauge_port_pkg::link_state_t lstate;

  wire bus_low = ~scl_q | ~sda_q;
  wire bus_timeout = bus_cnt >= BUS_TIMEOUT_CYC;

  always_ff @(posedge clk_link) begin
    if (link_rst || !bus_low || lstate == gauge_port_pkg::L_STUCK) begin
      bus_cnt <= 32'h0;
    end else if (!bus_timeout) begin
      bus_cnt <= bus_cnt + 32'h1;
    end
  end

  always_ff @(posedge clk_link) begin
    if (link_rst || lstate != gauge_port_pkg::L_STUCK) begin
      settle_cnt <= 4'h0;
    end else if (settle_cnt != gauge_port_pkg::STUCK_SETTLE_CYC) begin
      settle_cnt <= settle_cnt + 4'h1;
    end
  end

  // Only a line that stays low after our own release was settled counts
  wire link_stuck = lstate == gauge_port_pkg::L_STUCK &&
                    settle_cnt == gauge_port_pkg::STUCK_SETTLE_CYC && bus_low;

  // ------------------------------------------------------------
  // Link domain: byte engine
  // ------------------------------------------------------------
  logic [7:0] shreg;
  logic [3:0] bitcnt;
  logic sda_drive;
  logic scl_drive;
  logic is_read;
  logic wait_rd;
  logic [31:0] wait_cnt;
  logic req_tog;
  logic [7:0] sys_rsp;
  gauge_port_pkg::link_req_t req_hold;

  wire byte_done = bitcnt == gauge_port_pkg::BITS_PER_BYTE;
  wire addr_match = shreg[7:1] == gauge_port_pkg::TARGET_ADDR;
  wire [31:0] stretch_lim = link_sleep ? STRETCH_SLEEP_CYC : STRETCH_ACTIVE_CYC;
  wire wait_ack = ack_q == req_tog;
  wire wait_expired = wait_cnt >= stretch_lim;
  // Answer word settles before its ack toggle gets here, so it is read directly
  wire [7:0] wait_byte = wait_ack ? sys_rsp : gauge_port_pkg::READ_FILL;
  wire in_wait = lstate == gauge_port_pkg::L_WAIT;

  always_ff @(posedge clk_link) begin
    if (link_rst || !in_wait) begin
      wait_cnt <= 32'h0;
    end else if (!wait_expired) begin
      wait_cnt <= wait_cnt + 32'h1;
    end
  end

  always_ff @(posedge clk_link) begin
    if (link_rst) begin
      lstate <= gauge_port_pkg::L_IDLE;
      shreg <= 8'h0;
      bitcnt <= 4'h0;
      sda_drive <= 1'b0;
      scl_drive <= 1'b0;
      is_read <= 1'b0;
      wait_rd <= 1'b0;
      req_tog <= 1'b0;
      req_hold <= '0;
    end else if (link_off) begin
      // Fully off: both lines released, nothing answered
      lstate <= gauge_port_pkg::L_IDLE;
      sda_drive <= 1'b0;
      scl_drive <= 1'b0;
    end else if (bus_timeout && lstate != gauge_port_pkg::L_STUCK) begin
      lstate <= gauge_port_pkg::L_STUCK;
      sda_drive <= 1'b0;
      scl_drive <= 1'b0;
    end else if (start_seen) begin
      lstate <= gauge_port_pkg::L_ADDR;
      bitcnt <= 4'h0;
      sda_drive <= 1'b0;
      scl_drive <= 1'b0;
    end else if (stop_seen) begin
      lstate <= gauge_port_pkg::L_IDLE;
      sda_drive <= 1'b0;
      scl_drive <= 1'b0;
    end else begin
      case (lstate)
        gauge_port_pkg::L_ADDR, gauge_port_pkg::L_WR: begin
          if (scl_rise && !byte_done) begin
            shreg <= {shreg[6:0], sda_q};
            bitcnt <= bitcnt + 4'h1;
          end else if (scl_fall && byte_done) begin
            if (lstate == gauge_port_pkg::L_ADDR && !addr_match) begin
              lstate <= gauge_port_pkg::L_SKIP;
            end else begin
              // Ack driven and clock held while command logic takes the byte
              sda_drive <= 1'b1;
              scl_drive <= 1'b1;
              if (lstate == gauge_port_pkg::L_ADDR) begin
                is_read <= shreg[0];
              end
              req_hold <= '{is_addr: lstate == gauge_port_pkg::L_ADDR, is_read: 1'b0, data: shreg};
              req_tog <= ~req_tog;
              wait_rd <= 1'b0;
              lstate <= gauge_port_pkg::L_WAIT;
            end
          end
        end
        gauge_port_pkg::L_WAIT: begin
          if (wait_ack || wait_expired) begin
            scl_drive <= 1'b0;
            if (wait_rd) begin
              shreg <= wait_byte;
              sda_drive <= ~wait_byte[7];
              bitcnt <= 4'h0;
              lstate <= gauge_port_pkg::L_RD;
            end else begin
              lstate <= gauge_port_pkg::L_ACK;
            end
          end
        end
        gauge_port_pkg::L_ACK: begin
          if (scl_fall) begin
            sda_drive <= 1'b0;
            bitcnt <= 4'h0;
            if (is_read) begin
              scl_drive <= 1'b1;
              req_hold <= '{is_addr: 1'b0, is_read: 1'b1, data: 8'h0};
              req_tog <= ~req_tog;
              wait_rd <= 1'b1;
              lstate <= gauge_port_pkg::L_WAIT;
            end else begin
              lstate <= gauge_port_pkg::L_WR;
            end
          end
        end
        gauge_port_pkg::L_RD: begin
          if (scl_rise) begin
            bitcnt <= bitcnt + 4'h1;
          end else if (scl_fall) begin
            if (byte_done) begin
              sda_drive <= 1'b0;
              lstate <= gauge_port_pkg::L_RDACK;
            end else begin
              shreg <= {shreg[6:0], 1'b1};
              sda_drive <= ~shreg[6];
            end
          end
        end
        gauge_port_pkg::L_RDACK: begin
          // Host ack asks for the next byte of an incremental read
          if (scl_rise && sda_q) begin
            lstate <= gauge_port_pkg::L_SKIP;
          end else if (scl_fall) begin
            scl_drive <= 1'b1;
            req_hold <= '{is_addr: 1'b0, is_read: 1'b1, data: 8'h0};
            req_tog <= ~req_tog;
            wait_rd <= 1'b1;
            lstate <= gauge_port_pkg::L_WAIT;
          end
        end
        gauge_port_pkg::L_STUCK: begin
          if (!bus_low) begin
            lstate <= gauge_port_pkg::L_IDLE;
          end
        end
        default: begin
          sda_drive <= 1'b0;
          scl_drive <= 1'b0;
        end
      endcase
    end
  end

  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe_n = ~scl_drive;
  assign sda_oe_n = ~sda_drive;

  // ------------------------------------------------------------
  // System domain: synchronisers
  // ------------------------------------------------------------
  logic [2:0] sy_s1;
  logic [2:0] sy_s2;

  always_ff @(posedge clk_sys) begin
    sy_s1 <= {req_tog, link_stuck, alert_in};
    sy_s2 <= sy_s1;
  end

  wire req_s = sy_s2[2];
  wire stuck_s = sy_s2[1];
  wire alert_s = sy_s2[0];

  // ------------------------------------------------------------
  // System domain: byte handshake
  // ------------------------------------------------------------
  logic busy;
  logic seen;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      busy <= 1'b0;
      seen <= 1'b0;
      ack_tog <= 1'b0;
      sys_rsp <= gauge_port_pkg::READ_FILL;
      cmd <= '0;
    end else if (!busy && req_s != ack_tog && power_mode != gauge_port_pkg::M_SHUTDOWN) begin
      busy <= 1'b1;
      seen <= req_s;
      cmd <= req_hold;
    end else if (busy && rsp_valid) begin
      busy <= 1'b0;
      sys_rsp <= rsp_data;
      ack_tog <= seen;
    end
  end

  assign cmd_valid = busy;

  // ------------------------------------------------------------
  // System domain: power modes
  // ------------------------------------------------------------
  function automatic logic [15:0] magnitude(input logic signed [15:0] value);
    magnitude = value[15] ? 16'(-value) : 16'(value);
  endfunction : magnitude

  gauge_port_pkg::power_mode_t next_mode;
  logic [11:0] wake_cnt;

  wire current_low = magnitude(measured_current) < sleep_current_level;
  wire wake_armed = wake_cnt >= gauge_port_pkg::WAKE_LOW_TIME_CYC;

  always_comb begin
    next_mode = power_mode;
    case (power_mode)
      gauge_port_pkg::M_INIT: begin
        if (por_done) begin
          next_mode = gauge_port_pkg::M_NORMAL;
        end
      end
      gauge_port_pkg::M_NORMAL: begin
        if (shutdown_cmd) begin
          next_mode = gauge_port_pkg::M_SHUTDOWN;
        end else if ((sleep_enable && current_low) || stuck_s) begin
          next_mode = gauge_port_pkg::M_SLEEP;
        end
      end
      gauge_port_pkg::M_SLEEP: begin
        if (shutdown_cmd) begin
          next_mode = gauge_port_pkg::M_SHUTDOWN;
        end else if (!current_low && !stuck_s) begin
          next_mode = gauge_port_pkg::M_NORMAL;
        end
      end
      default: begin
        if (wake_armed && alert_s) begin
          next_mode = gauge_port_pkg::M_INIT;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst || power_mode != gauge_port_pkg::M_SHUTDOWN || alert_s) begin
      wake_cnt <= 12'h0;
    end else if (!wake_armed) begin
      wake_cnt <= wake_cnt + 12'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      power_mode <= gauge_port_pkg::M_INIT;
      por_start <= 1'b1;
      regulator_enable <= 1'b1;
      gauging_enable <= 1'b0;
    end else begin
      power_mode <= next_mode;
      por_start <= next_mode == gauge_port_pkg::M_INIT && power_mode == gauge_port_pkg::M_SHUTDOWN;
      // Dropped at once, well inside the allowed entry time
      regulator_enable <= next_mode != gauge_port_pkg::M_SHUTDOWN;
      gauging_enable <= !config_update && (next_mode == gauge_port_pkg::M_NORMAL ||
                        next_mode == gauge_port_pkg::M_SLEEP);
    end
  end

  assign mode_sleep = power_mode == gauge_port_pkg::M_SLEEP;
  assign mode_off = power_mode == gauge_port_pkg::M_SHUTDOWN;

  // ------------------------------------------------------------
  // System domain: charge and level flags
  // ------------------------------------------------------------
  logic charge_hit_d;
  logic [7:0] soc_d;

  wire charge_hit = charge_alert_enable && (summed_charge >= charge_alert_level ||
                    summed_charge_duration >= duration_alert_level);
  wire charge_set = charge_hit && !charge_hit_d;
  wire dsg_cross = !charging && soc_d > charge_level_trigger_dsg && soc <= charge_level_trigger_dsg;
  wire chg_cross = charging && soc_d < charge_level_trigger_chg && soc >= charge_level_trigger_chg;
  wire level_set = dsg_cross || chg_cross;

  // A set arriving with a clear wins so no crossing is lost
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      charge_hit_d <= 1'b0;
      soc_d <= 8'h0;
      charge_flag <= 1'b0;
      level_flag <= 1'b0;
    end else begin
      charge_hit_d <= charge_hit;
      soc_d <= soc;
      charge_flag <= charge_set || (charge_flag && !flag_clear);
      level_flag <= level_set || (level_flag && !flag_clear);
    end
  end

  // Pin is an input while shut down so the host can wake us
  assign alert_out = 1'b0;
  assign alert_oe_n = !((charge_flag || level_flag) && !mode_off);

endmodule : gauge_host_port
`default_nettype wire

// ---- testbench/gauge_host_port_chk.sv ----
// Assertion checker for the gauge host port
`timescale 1ns/10ps
`default_nettype none
module gauge_host_port_chk #(
  parameter int unsigned BUS_TIMEOUT_CYC = 2000
) (
  // Clocks and reset
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_link,
  // Serial pins
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic scl_oe_n,
  input wire logic sda_oe_n,
  // Power
  input wire logic por_done,
  input wire logic regulator_enable,
  input wire gauge_port_pkg::power_mode_t power_mode,
  input wire logic shutdown_cmd,
  input wire logic config_update,
  input wire logic gauging_enable,
  // Flags
  input wire logic charge_alert_enable,
  input wire logic [31:0] summed_charge,
  input wire logic [31:0] charge_alert_level,
  input wire logic charge_flag,
  input wire logic charging,
  input wire logic [7:0] soc,
  input wire logic [7:0] charge_level_trigger_dsg,
  input wire logic level_flag
);
  // ----
  // Bus low time
  // ----
  // Margin of 8 covers the pin synchronisers and the output flop
  int unsigned low_cnt;
  always_ff @(posedge clk_link) begin
    if (rst || (scl_in && sda_in)) begin
      low_cnt <= 0;
    end else begin
      low_cnt <= low_cnt + 1;
    end
  end
  property p_release;
    @(posedge clk_link) disable iff (rst) low_cnt > BUS_TIMEOUT_CYC + 8 |-> scl_oe_n && sda_oe_n;
  endproperty
  a_release: assert property (p_release) else $error("bus held too long");
  property p_shut;
    @(posedge clk_sys) disable iff (rst)
      shutdown_cmd && power_mode inside {gauge_port_pkg::M_NORMAL, gauge_port_pkg::M_SLEEP}
      |=> power_mode == gauge_port_pkg::M_SHUTDOWN && !regulator_enable;
  endproperty
  a_shut: assert property (p_shut) else $error("shutdown not entered");
  property p_only_cmd;
    @(posedge clk_sys) disable iff (rst)
      power_mode == gauge_port_pkg::M_SHUTDOWN && $past(power_mode) != gauge_port_pkg::M_SHUTDOWN |-> $past(shutdown_cmd);
  endproperty
  a_only_cmd: assert property (p_only_cmd) else $error("shutdown without command");
  property p_reg_off;
    @(posedge clk_sys) disable iff (rst) power_mode == gauge_port_pkg::M_SHUTDOWN |-> !regulator_enable;
  endproperty
  a_reg_off: assert property (p_reg_off) else $error("regulator on in shutdown");
  property p_init;
    @(posedge clk_sys) disable iff (rst)
      power_mode == gauge_port_pkg::M_INIT && por_done |-> ##[1:4] power_mode == gauge_port_pkg::M_NORMAL;
  endproperty
  a_init: assert property (p_init) else $error("init did not end");
  property p_gauge;
    @(posedge clk_sys) disable iff (rst) config_update ##1 config_update |-> !gauging_enable;
  endproperty
  a_gauge: assert property (p_gauge) else $error("gauging during update");
  property p_charge;
    @(posedge clk_sys) disable iff (rst)
      $rose(charge_alert_enable && summed_charge >= charge_alert_level) |-> ##[0:2] charge_flag;
  endproperty
  a_charge: assert property (p_charge) else $error("charge flag missing");
  property p_level;
    @(posedge clk_sys) disable iff (rst)
      !charging && $past(soc) > charge_level_trigger_dsg && soc < charge_level_trigger_dsg |-> ##[0:2] level_flag;
  endproperty
  a_level: assert property (p_level) else $error("level flag missing");
endmodule : gauge_host_port_chk

bind gauge_host_port gauge_host_port_chk #(.BUS_TIMEOUT_CYC(BUS_TIMEOUT_CYC)) i_chk (
  .clk_sys, .rst, .clk_link, .scl_in, .sda_in, .scl_oe_n, .sda_oe_n, .por_done, .regulator_enable,
  .power_mode, .shutdown_cmd, .config_update, .gauging_enable, .charge_alert_enable, .summed_charge,
  .charge_alert_level, .charge_flag, .charging, .soc, .charge_level_trigger_dsg, .level_flag);
`default_nettype wire

// ---- testbench/i2c_host_model.sv ----
// Host controller model on the serial pins
`timescale 1ns/10ps
`default_nettype none
module i2c_host_model #(
  parameter int HALF = 8,
  parameter int GAP = 11000
) (
  // Link clock and wire levels
  input wire logic clk_link,
  input wire logic scl,
  input wire logic sda,
  // Pull-low requests
  output logic scl_low = 1'b0,
  output logic sda_low = 1'b0
);
  task automatic tick(input int n);
    repeat (n) @(posedge clk_link);
  endtask : tick
  // Release the clock and wait out a stretch, bounded
  task automatic rise();
    int k;
    scl_low <= 1'b0;
    k = 0;
    while (scl !== 1'b1 && k < 2000) begin
      tick(1);
      k++;
    end
    tick(HALF);
  endtask : rise
  task automatic bitx(input logic b, output logic r);
    sda_low <= !b;
    tick(HALF);
    rise();
    r = sda;
    scl_low <= 1'b1;
    tick(2);
  endtask : bitx
  // MSB first, then the acknowledge bit
  task automatic xbyte(input logic [7:0] d, input logic ab, output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], q[i]);
    end
    bitx(ab, a);
  endtask : xbyte
  task automatic start();
    tick(GAP);
    sda_low <= 1'b1;
    tick(HALF);
    scl_low <= 1'b1;
    tick(HALF);
  endtask : start
  task automatic stop();
    sda_low <= 1'b1;
    tick(HALF);
    rise();
    sda_low <= 1'b0;
    tick(HALF);
  endtask : stop
  task automatic hold(input int n);
    scl_low <= 1'b1;
    tick(n);
    scl_low <= 1'b0;
  endtask : hold
endmodule : i2c_host_model
`default_nettype wire

// ---- testbench/tb.sv ----
// Self-checking testbench for the gauge host port
`timescale 1ns/10ps
`default_nettype none
module tb;
  // ----
  // Stimulus and wires
  // ----
  logic clk_sys = 1'b0;
  logic clk_link = 1'b0;
  logic rst = 1'b1;
  logic alert_drv = 1'b1;
  logic por_done = 1'b0;
  logic sleep_enable = 1'b0;
  logic signed [15:0] measured_current = 16'sh01f4;
  logic [15:0] sleep_current_level = 16'h0064;
  logic shutdown_cmd = 1'b0;
  logic config_update = 1'b0;
  logic charge_alert_enable = 1'b0;
  logic [31:0] summed_charge = 32'h0;
  logic [31:0] summed_charge_duration = 32'h0;
  logic [31:0] charge_alert_level = 32'h64;
  logic [31:0] duration_alert_level = 32'h64;
  logic charging = 1'b0;
  logic [7:0] soc = 8'h3c;
  logic [7:0] charge_level_trigger_chg = 8'h50;
  logic [7:0] charge_level_trigger_dsg = 8'h32;
  logic flag_clear = 1'b0;
  logic rsp_valid = 1'b0;
  logic [7:0] rsp_data = 8'h3c;
  logic scl_oe_n, sda_oe_n, alert_oe_n, por_start, regulator_enable, gauging_enable;
  logic charge_flag, level_flag, cmd_valid, h_scl, h_sda;
  gauge_port_pkg::power_mode_t power_mode;
  gauge_port_pkg::link_req_t cmd;
  gauge_port_pkg::link_req_t lg [0:7];
  int nl = 0;
  int error_cnt = 0;
  int checked = 0;
  // Pull-ups on every line
  wire scl_w = !(h_scl || scl_oe_n === 1'b0);
  wire sda_w = !(h_sda || sda_oe_n === 1'b0);
  wire alert_w = alert_drv && (alert_oe_n !== 1'b0);
  always #2 clk_sys = ~clk_sys;
  initial begin
    #1.1;
    forever #3 clk_link = ~clk_link;
  end
  gauge_host_port #(.BUS_TIMEOUT_CYC(2000), .STRETCH_SLEEP_CYC(200), .STRETCH_ACTIVE_CYC(400)) i_gauge_host_port (
    .clk_sys, .rst, .clk_link, .scl_in(scl_w), .scl_out(), .scl_oe_n, .sda_in(sda_w), .sda_out(), .sda_oe_n,
    .alert_in(alert_w), .alert_out(), .alert_oe_n, .por_done, .por_start, .regulator_enable, .power_mode,
    .sleep_enable, .measured_current, .sleep_current_level, .shutdown_cmd, .config_update, .gauging_enable,
    .charge_alert_enable, .summed_charge, .summed_charge_duration, .charge_alert_level, .duration_alert_level,
    .charge_flag, .charging, .soc, .charge_level_trigger_chg, .charge_level_trigger_dsg, .level_flag,
    .flag_clear, .cmd_valid, .cmd, .rsp_valid, .rsp_data);
  i2c_host_model i_i2c_host_model (.clk_link, .scl(scl_w), .sda(sda_w), .scl_low(h_scl), .sda_low(h_sda));
  // Command side answers every byte one cycle after it appears
  always @(posedge clk_sys) begin
    rsp_valid <= cmd_valid && !rsp_valid;
    if (cmd_valid && rsp_valid) begin
      lg[nl[2:0]] <= cmd;
      nl <= nl + 1;
    end
  end
  // ----
  // Helpers
  // ----
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc
  task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic clr();
    flag_clear <= 1'b1;
    cyc(1);
    flag_clear <= 1'b0;
    cyc(2);
  endtask : clr
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop
  // ----
  // Scenarios
  // ----
  task automatic t_power();
    chk("mode", power_mode, gauge_port_pkg::M_INIT);
    por_done <= 1'b1;
    cyc(6);
    chk("mode", power_mode, gauge_port_pkg::M_NORMAL);
    config_update <= 1'b1;
    cyc(3);
    chk("gauging", gauging_enable, 0);
    config_update <= 1'b0;
    cyc(3);
    chk("gauging", gauging_enable, 1);
  endtask : t_power
  // Address byte, then data or reads; n is the expected command count
  task automatic t_xfer(input logic [7:0] ad, input int nr, input logic [7:0] wd, input int n);
    logic [7:0] q;
    logic a;
    int n0;
    n0 = nl;
    i_i2c_host_model.start();
    i_i2c_host_model.xbyte(ad, 1'b1, q, a);
    chk("addr ack", a, n == 0);
    if (ad == 8'haa) begin
      i_i2c_host_model.xbyte(wd, 1'b1, q, a);
      chk("data ack", a, 0);
    end
    for (int i = 1; i <= nr; i++) begin
      i_i2c_host_model.xbyte(8'hff, i == nr, q, a);
      chk("read", q, 8'h3c);
    end
    i_i2c_host_model.stop();
    cyc(4);
    chk("count", nl - n0, n);
    if (n > 0) begin
      chk("addr cmd", {lg[n0[2:0]].is_addr, lg[n0[2:0]].data}, {1'b1, ad});
      chk("next cmd", lg[3'(n0 + 1)], ad == 8'haa ? {2'b00, wd} : {2'b01, 8'h00});
    end
  endtask : t_xfer
  task automatic t_sleep();
    sleep_enable <= 1'b1;
    measured_current <= 16'sh0005;
    cyc(8);
    chk("mode", power_mode, gauge_port_pkg::M_SLEEP);
    measured_current <= -16'sh01f4;
    cyc(30);
    chk("mode", power_mode, gauge_port_pkg::M_NORMAL);
    sleep_enable <= 1'b0;
  endtask : t_sleep
  task automatic t_flags();
    charge_alert_enable <= 1'b1;
    summed_charge <= 32'h64;
    cyc(4);
    chk("charge", charge_flag, 1);
    clr();
    chk("charge", charge_flag, 0);
    summed_charge <= 32'h0;
    cyc(2);
    summed_charge_duration <= 32'hc8;
    cyc(4);
    chk("duration", charge_flag, 1);
    chk("alert pin", alert_oe_n, 0);
    soc <= 8'h28;
    cyc(4);
    chk("dsg level", level_flag, 1);
    clr();
    charging <= 1'b1;
    soc <= 8'h5a;
    cyc(4);
    chk("chg level", level_flag, 1);
    clr();
    charge_alert_enable <= 1'b0;
  endtask : t_flags
  task automatic t_stuck();
    logic b;
    i_i2c_host_model.start();
    for (int i = 7; i >= 0; i--) begin
      i_i2c_host_model.bitx(gauge_port_pkg::ADDR_BYTE_WR[i], b);
    end
    i_i2c_host_model.sda_low <= 1'b0;
    i_i2c_host_model.tick(8);
    i_i2c_host_model.rise();
    chk("ack held", sda_oe_n, 0);
    cyc(3100);
    chk("ack released", sda_oe_n, 1);
    fork
      i_i2c_host_model.hold(2300);
    join_none
    cyc(3300);
    chk("released", {scl_oe_n, sda_oe_n}, 2'b11);
    chk("mode", power_mode, gauge_port_pkg::M_SLEEP);
    cyc(600);
    chk("mode", power_mode, gauge_port_pkg::M_NORMAL);
  endtask : t_stuck
  task automatic t_shutdown();
    int k;
    por_done <= 1'b0;
    shutdown_cmd <= 1'b1;
    cyc(1);
    shutdown_cmd <= 1'b0;
    cyc(1);
    chk("mode", power_mode, gauge_port_pkg::M_SHUTDOWN);
    chk("regulator", regulator_enable, 0);
    alert_drv <= 1'b0;
    cyc(2600);
    alert_drv <= 1'b1;
    k = 0;
    repeat (8) begin
      cyc(1);
      if (por_start === 1'b1) k++;
    end
    chk("mode", power_mode, gauge_port_pkg::M_INIT);
    chk("por pulse", k, 1);
    por_done <= 1'b1;
    cyc(6);
    chk("mode", power_mode, gauge_port_pkg::M_NORMAL);
  endtask : t_shutdown
  initial begin
    cyc(16);
    rst <= 1'b0;
    cyc(2);
    t_power();
    t_xfer(8'haa, 0, 8'h5a, 2);
    t_xfer(8'hab, 2, 8'h00, 3);
    t_xfer(8'h84, 0, 8'h00, 0);
    t_sleep();
    t_flags();
    t_stuck();
    t_shutdown();
    report_and_stop();
  end
  initial begin
    #400000;
    error_cnt++;
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
